// >>> shared/bfi_consts.svh
// Purpose: constants shared by both ends of the serial link
// Assumes: 20 MHz mclk, link clock sampled as a plain input
// Notes: include by bare name
`ifndef BFI_CONSTS_SVH
`define BFI_CONSTS_SVH
`define BFI_SLAVE_ADDR 7'h2C
`define BFI_REG_BRT 8'h00
`define BFI_REG_CTRL 8'h01
`define BFI_REG_FAULT 8'h02
`define BFI_REG_ID 8'h03
`define BFI_FAULT_RST 8'h00
`define BFI_ID_VALUE 8'h5A
`define BFI_BIT_OPEN 7
`define BFI_BIT_SHORT 6
`define BFI_BIT_OC 2
`define BFI_BIT_TH 1
`define BFI_BIT_UV 0
`define BFI_VREQ_MAX 6'h3F
`define BFI_CLK_NS 50
`define BFI_SCL_HALF_NS 2500
`define BFI_SCL_HALF_CYC (`BFI_SCL_HALF_NS / `BFI_CLK_NS)
`define BFI_DIV_W 7
`define BFI_BITS 4'h8
`define BFI_NSTR 6
`endif

// >>> shared/bfi_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes: no constants here
package bfi_pkg;
  typedef enum logic [2:0] {
    BFI_S_IDLE, BFI_S_ADDR, BFI_S_ADDR_ACK, BFI_S_RX, BFI_S_RX_ACK,
    BFI_S_TX, BFI_S_TX_ACK, BFI_S_IGNORE
  } bfi_slv_st_t;
  typedef enum logic [3:0] {
    BFI_M_IDLE, BFI_M_START, BFI_M_BIT_LO, BFI_M_BIT_HI, BFI_M_ACK_LO,
    BFI_M_ACK_HI, BFI_M_STOP_LO, BFI_M_STOP_HI, BFI_M_RS_LO, BFI_M_RS_HI
  } bfi_mst_st_t;
endpackage

// >>> shared/bfi_if.sv
// Purpose: two-wire link joining master end and slave end
// Assumes: open-drain lines with pull-up
// Notes: wired-and worked out here from the enables
`timescale 1ns/1ps
interface bfi_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe,
    output sda_m_o, output sda_m_oe);
endinterface

// >>> core/bfi_slave.sv
// Purpose: fault status logic and serial slave for the backlight driver
// Assumes: bus lines sampled twice on mclk before use
// Notes: only the fault register clears on read
// Function
// - open fault at max request and low
// - open decision ignores measured boost voltage
// - raise request while any low comparator
// - short when optimized plus other high string
// - fault register read clears string, oc, thermal
// - undervoltage off, or low/high threshold select
// - undervoltage stops leds and boost, hysteresis restart
// - undervoltage bit cleared by pin low or read
// - overcurrent stops boost until current drops
// - thermal stop at 150, resume below 130
// - sample with clock high, abort on glitch
// - eight bits msb first then ack
// - detect start and stop conditions
// - busy from start until stop
// - release or pull low on ninth pulse
// - master nacks last read byte
// - respond to address 2Ch, bit eight direction
// - ack only on address match
// - write index then data, index increments
// - read returns data, index advances on ack
// - repeated start restarts address reception
`timescale 1ns/1ps
`include "bfi_consts.svh"
module bfi_slave (
  input wire logic mclk,
  input wire logic srst,
  bfi_if.slave bus,
  input wire logic [`BFI_NSTR-1:0] cmp_low,
  input wire logic [`BFI_NSTR-1:0] cmp_mid,
  input wire logic [`BFI_NSTR-1:0] cmp_high,
  input wire logic undervoltage_detect_enable,
  input wire logic undervoltage_threshold_select,
  input wire logic vin_above_low_set,
  input wire logic vin_above_low_clr,
  input wire logic vin_above_high_set,
  input wire logic vin_above_high_clr,
  input wire logic boost_overcurrent,
  input wire logic temp_at_150,
  input wire logic temp_below_130,
  input wire logic enable_io_supply_pin,
  output logic [5:0] boost_request,
  output logic led_enable,
  output logic boost_enable,
  output logic bus_busy,
  output logic [7:0] brightness
);
  // two-stage samplers for every outside level except the undervoltage enable and select
  logic [1:0] scl_s_r, sda_s_r;
  logic scl_r, sda_r;
  logic [`BFI_NSTR-1:0] low_a_r, low_b_r, mid_a_r, mid_b_r, hi_a_r, hi_b_r;
  logic [7:0] misc_a_r, misc_b_r;
  always_ff @(posedge mclk) begin
    scl_s_r <= {scl_s_r[0], bus.scl};
    sda_s_r <= {sda_s_r[0], bus.sda};
    low_a_r <= cmp_low; low_b_r <= low_a_r;
    mid_a_r <= cmp_mid; mid_b_r <= mid_a_r;
    hi_a_r <= cmp_high; hi_b_r <= hi_a_r;
    misc_a_r <= {vin_above_low_set, vin_above_low_clr, vin_above_high_set,
      vin_above_high_clr, boost_overcurrent, temp_at_150, temp_below_130,
      enable_io_supply_pin};
    misc_b_r <= misc_a_r;
    scl_r <= scl_s_r[1];
    sda_r <= sda_s_r[1];
  end
  wire scl_q = scl_s_r[1];
  wire sda_q = sda_s_r[1];
  wire scl_rise = scl_q & ~scl_r;
  wire scl_fall = ~scl_q & scl_r;
  wire start_cond = scl_q & scl_r & sda_r & ~sda_q;
  wire stop_cond = scl_q & scl_r & ~sda_r & sda_q;

  // fault logic
  logic [5:0] vreq_r;
  logic open_r, short_r, oc_r, th_r, uv_r, uv_act_r, th_act_r;
  logic fault_rd;
  wire any_low = |low_b_r;
  wire [`BFI_NSTR-1:0] optim = ~mid_b_r & ~low_b_r;
  wire at_max = (vreq_r == `BFI_VREQ_MAX);
  wire open_now = at_max & any_low;
  logic short_now;
  always_comb begin
    short_now = 1'b0;
    for (int i = 0; i < `BFI_NSTR; i++) begin
      if (optim[i] && |(hi_b_r & ~(6'h01 << i))) begin
        short_now = 1'b1;
      end
    end
  end
  // hysteresis comes from separate set and clear comparators
  wire uv_trip = undervoltage_detect_enable & (undervoltage_threshold_select ?
    ~misc_b_r[5] : ~misc_b_r[7]);
  wire uv_ok = undervoltage_threshold_select ? misc_b_r[4] : misc_b_r[6];
  wire oc_in = misc_b_r[3];
  wire en_pin_q = misc_b_r[0];
  always_ff @(posedge mclk) begin
    if (srst) begin
      vreq_r <= 6'h00;
      open_r <= 1'b0; short_r <= 1'b0; oc_r <= 1'b0;
      th_r <= 1'b0; uv_r <= 1'b0; uv_act_r <= 1'b0; th_act_r <= 1'b0;
    end else begin
      if (any_low && !at_max) vreq_r <= vreq_r + 6'h01;
      // set wins over a clearing read
      open_r <= open_now | (open_r & ~fault_rd);
      short_r <= short_now | (short_r & ~fault_rd);
      oc_r <= oc_in | (oc_r & ~fault_rd);
      th_r <= misc_b_r[2] | (th_r & ~fault_rd);
      uv_r <= uv_trip | (uv_r & ~fault_rd & en_pin_q);
      if (uv_trip) uv_act_r <= 1'b1;
      else if (uv_ok || !undervoltage_detect_enable) uv_act_r <= 1'b0;
      if (misc_b_r[2]) th_act_r <= 1'b1;
      else if (misc_b_r[1]) th_act_r <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      led_enable <= 1'b0; boost_enable <= 1'b0; boost_request <= 6'h00;
    end else begin
      led_enable <= ~uv_act_r & ~th_act_r;
      boost_enable <= ~uv_act_r & ~th_act_r & ~oc_in;
      boost_request <= vreq_r;
    end
  end
  wire [7:0] fault_val = {open_r, short_r, 3'b000, oc_r, th_r, uv_r};

  // serial slave
  bfi_pkg::bfi_slv_st_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, idx_r, brt_r, ctrl_r, tx_r;
  logic rw_r, idx_ok_r, sda_lo_r, hi_chk_r, hi_sda_r;
  // two-entry buffer between byte receiver and register file
  logic [7:0] fb_d_r [2];
  logic [7:0] fb_a_r [2];
  logic [1:0] fb_cnt_r;
  logic fb_wp_r, fb_rp_r;
  wire fb_in_ready = (fb_cnt_r != 2'd2);
  wire fb_out_valid = (fb_cnt_r != 2'd0);
  wire fb_out_ready = 1'b1;
  logic fb_push;
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
      input logic [7:0] f, input logic [7:0] b, input logic [7:0] c);
    case (a)
      `BFI_REG_BRT: rd_mux = b;
      `BFI_REG_CTRL: rd_mux = c;
      `BFI_REG_FAULT: rd_mux = f;
      `BFI_REG_ID: rd_mux = `BFI_ID_VALUE; // arbitrary id value
      default: rd_mux = 8'h00;
    endcase
  endfunction
  wire [7:0] rd_val = rd_mux(idx_r, fault_val, brt_r, ctrl_r);
  wire addr_hit = (sh_r[7:1] == `BFI_SLAVE_ADDR);
  wire glitch = hi_chk_r & scl_q & (sda_q != hi_sda_r) &
    (st_r != bfi_pkg::BFI_S_IDLE);
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= bfi_pkg::BFI_S_IDLE; cnt_r <= 4'h0; sh_r <= 8'h00;
      idx_r <= 8'h00; rw_r <= 1'b0; idx_ok_r <= 1'b0; sda_lo_r <= 1'b0;
      tx_r <= 8'h00; bus_busy <= 1'b0; fault_rd <= 1'b0; fb_push <= 1'b0;
      hi_chk_r <= 1'b0; hi_sda_r <= 1'b1;
    end else begin
      fault_rd <= 1'b0;
      fb_push <= 1'b0;
      if (scl_rise) begin hi_chk_r <= 1'b1; hi_sda_r <= sda_q; end
      else if (scl_fall) hi_chk_r <= 1'b0;
      if (start_cond) begin
        bus_busy <= 1'b1;
        st_r <= bfi_pkg::BFI_S_ADDR;
        cnt_r <= 4'h0; sda_lo_r <= 1'b0; hi_chk_r <= 1'b0;
      end else if (stop_cond) begin
        bus_busy <= 1'b0;
        st_r <= bfi_pkg::BFI_S_IDLE; sda_lo_r <= 1'b0; hi_chk_r <= 1'b0;
      end else if (glitch) begin
        st_r <= bfi_pkg::BFI_S_IGNORE; sda_lo_r <= 1'b0;
      end else begin
        case (st_r)
          bfi_pkg::BFI_S_ADDR, bfi_pkg::BFI_S_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_q};
              cnt_r <= cnt_r + 4'h1;
            end
            if (scl_fall && cnt_r == `BFI_BITS) begin
              cnt_r <= 4'h0;
              if (st_r == bfi_pkg::BFI_S_ADDR) begin
                rw_r <= sh_r[0];
                sh_r <= {1'b0, sh_r[7:1]};
                if (addr_hit) begin
                  sda_lo_r <= 1'b1;
                  st_r <= bfi_pkg::BFI_S_ADDR_ACK;
                end else st_r <= bfi_pkg::BFI_S_IGNORE;
              end else if (fb_in_ready || !idx_ok_r) begin
                sda_lo_r <= 1'b1;
                st_r <= bfi_pkg::BFI_S_RX_ACK;
                if (!idx_ok_r) begin idx_r <= sh_r; idx_ok_r <= 1'b1; end
                else fb_push <= 1'b1;
              end else st_r <= bfi_pkg::BFI_S_IGNORE; // full: nack
            end
          end
          bfi_pkg::BFI_S_ADDR_ACK: if (scl_fall) begin
            sda_lo_r <= 1'b0;
            if (rw_r) begin
              st_r <= bfi_pkg::BFI_S_TX; tx_r <= rd_val;
              sda_lo_r <= ~rd_val[7];
              cnt_r <= 4'h1;
              fault_rd <= (idx_r == `BFI_REG_FAULT);
            end else begin
              st_r <= bfi_pkg::BFI_S_RX; idx_ok_r <= 1'b0;
            end
          end
          bfi_pkg::BFI_S_RX_ACK: if (scl_fall) begin
            sda_lo_r <= 1'b0; st_r <= bfi_pkg::BFI_S_RX;
          end
          bfi_pkg::BFI_S_TX: if (scl_fall) begin
            if (cnt_r == `BFI_BITS) begin
              sda_lo_r <= 1'b0; st_r <= bfi_pkg::BFI_S_TX_ACK;
            end else begin
              sda_lo_r <= ~tx_r[3'd7 - cnt_r[2:0]];
              cnt_r <= cnt_r + 4'h1;
            end
          end
          bfi_pkg::BFI_S_TX_ACK: begin
            if (scl_rise) begin
              if (sda_q) st_r <= bfi_pkg::BFI_S_IGNORE;
              else idx_r <= idx_r + 8'h01;
            end
            if (scl_fall) begin
              st_r <= bfi_pkg::BFI_S_TX; tx_r <= rd_val;
              sda_lo_r <= ~rd_val[7]; cnt_r <= 4'h1;
              fault_rd <= (idx_r == `BFI_REG_FAULT);
            end
          end
          bfi_pkg::BFI_S_IGNORE: sda_lo_r <= 1'b0;
          default: st_r <= bfi_pkg::BFI_S_IDLE;
        endcase
      end
      if (fb_push) idx_r <= idx_r + 8'h01;
    end
  end
  // buffer and register writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      fb_cnt_r <= 2'd0; fb_wp_r <= 1'b0; fb_rp_r <= 1'b0;
      brt_r <= 8'h00; ctrl_r <= 8'h00;
    end else begin
      if (fb_push) begin
        fb_d_r[fb_wp_r] <= sh_r; fb_a_r[fb_wp_r] <= idx_r;
        fb_wp_r <= ~fb_wp_r;
      end
      if (fb_out_valid && fb_out_ready) begin
        fb_rp_r <= ~fb_rp_r;
        if (fb_a_r[fb_rp_r] == `BFI_REG_BRT) brt_r <= fb_d_r[fb_rp_r];
        if (fb_a_r[fb_rp_r] == `BFI_REG_CTRL) ctrl_r <= fb_d_r[fb_rp_r];
      end
      fb_cnt_r <= fb_cnt_r + {1'b0, fb_push} -
        {1'b0, fb_out_valid & fb_out_ready};
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) brightness <= 8'h00;
    else brightness <= brt_r;
  end
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_lo_r;
endmodule // bfi_slave

// >>> core/bfi_master.sv
// Purpose: serial master end driving the link clock
// Assumes: one byte per request, user side handshake
// Notes: link clock made by dividing mclk
`timescale 1ns/1ps
`include "bfi_consts.svh"
module bfi_master (
  input wire logic mclk,
  input wire logic srst,
  bfi_if.master bus,
  input wire logic req_valid,
  input wire logic req_start,
  input wire logic req_stop,
  input wire logic req_read,
  input wire logic req_last,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  bfi_pkg::bfi_mst_st_t st_r;
  logic [`BFI_DIV_W-1:0] div_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic scl_lo_r, sda_lo_r, rd_r, last_r, stop_r;
  logic [1:0] sda_s_r;
  always_ff @(posedge mclk) sda_s_r <= {sda_s_r[0], bus.sda};
  wire tick = (div_r == `BFI_DIV_W'(`BFI_SCL_HALF_CYC - 1));
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= bfi_pkg::BFI_M_IDLE; div_r <= '0; cnt_r <= 4'h0;
      sh_r <= 8'h00; scl_lo_r <= 1'b0; sda_lo_r <= 1'b0; rd_r <= 1'b0;
      last_r <= 1'b0; stop_r <= 1'b1; req_ready <= 1'b0;
      rsp_valid <= 1'b0; rsp_data <= 8'h00; rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      div_r <= tick ? '0 : div_r + `BFI_DIV_W'(1);
      if (tick) begin
        case (st_r)
          // clock parks low between bytes so a repeated start can be formed
          bfi_pkg::BFI_M_IDLE: if (!stop_r && !scl_lo_r) begin
            scl_lo_r <= 1'b1;
          end else if (req_valid) begin
            req_ready <= 1'b1;
            sh_r <= req_data; rd_r <= req_read; last_r <= req_last;
            stop_r <= req_stop; cnt_r <= 4'h0;
            if (req_start && scl_lo_r) st_r <= bfi_pkg::BFI_M_RS_LO;
            else if (req_start) begin
              sda_lo_r <= 1'b1; st_r <= bfi_pkg::BFI_M_START;
            end else st_r <= bfi_pkg::BFI_M_BIT_LO;
          end
          bfi_pkg::BFI_M_RS_LO: begin
            sda_lo_r <= 1'b0; scl_lo_r <= 1'b0; st_r <= bfi_pkg::BFI_M_RS_HI;
          end
          bfi_pkg::BFI_M_RS_HI: begin
            sda_lo_r <= 1'b1; st_r <= bfi_pkg::BFI_M_START;
          end
          bfi_pkg::BFI_M_START: begin
            scl_lo_r <= 1'b1; st_r <= bfi_pkg::BFI_M_BIT_LO;
          end
          bfi_pkg::BFI_M_BIT_LO: begin
            scl_lo_r <= 1'b1;
            sda_lo_r <= rd_r ? 1'b0 : ~sh_r[7];
            st_r <= bfi_pkg::BFI_M_BIT_HI;
          end
          bfi_pkg::BFI_M_BIT_HI: begin
            scl_lo_r <= 1'b0;
            sh_r <= {sh_r[6:0], sda_s_r[1]};
            cnt_r <= cnt_r + 4'h1;
            st_r <= (cnt_r == `BFI_BITS - 4'h1) ? bfi_pkg::BFI_M_ACK_LO
              : bfi_pkg::BFI_M_BIT_LO;
          end
          bfi_pkg::BFI_M_ACK_LO: begin
            scl_lo_r <= 1'b1;
            sda_lo_r <= rd_r & ~last_r;
            st_r <= bfi_pkg::BFI_M_ACK_HI;
          end
          bfi_pkg::BFI_M_ACK_HI: begin
            scl_lo_r <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data <= sh_r;
            rsp_nack <= rd_r ? last_r : sda_s_r[1];
            st_r <= stop_r ? bfi_pkg::BFI_M_STOP_LO : bfi_pkg::BFI_M_IDLE;
          end
          bfi_pkg::BFI_M_STOP_LO: begin
            scl_lo_r <= 1'b1; sda_lo_r <= 1'b1; st_r <= bfi_pkg::BFI_M_STOP_HI;
          end
          bfi_pkg::BFI_M_STOP_HI: begin
            if (scl_lo_r) scl_lo_r <= 1'b0;
            else begin
              sda_lo_r <= 1'b0; st_r <= bfi_pkg::BFI_M_IDLE;
            end
          end
          default: st_r <= bfi_pkg::BFI_M_IDLE;
        endcase
      end
    end
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_lo_r;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_lo_r;
endmodule // bfi_master

// >>> dv/bfi_link_asserts.sv
// Purpose: wire checks on the two-wire link between both ends
// Assumes: mclk samples the resolved lines, srst synchronous high
// Notes: byte position is tracked from start conditions on the wire
`timescale 1ns/1ps
`include "bfi_consts.svh"
module bfi_link_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_r, sda_q_r, first_r, sel_r, rd_r, skip_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  wire s_pull = sda_s_oe & ~sda_s_o;
  wire m_pull = sda_m_oe & ~sda_m_o;
  wire rise = scl & ~scl_q_r;
  wire start = scl & scl_q_r & sda_q_r & ~sda;
  wire stop = scl & scl_q_r & ~sda_q_r & sda;
  wire ack_pulse = rise & (cnt_r == 4'h8);
  wire hit = (sh_r[7:1] == `BFI_SLAVE_ADDR);
  wire addr_bits = first_r & ~ack_pulse;
  wire data_ack = ack_pulse & ~first_r & sel_r;
  always_ff @(posedge mclk) begin
    scl_q_r <= scl;
    sda_q_r <= sda;
    if (rise & (cnt_r < 4'h8)) begin
      sh_r <= {sh_r[6:0], sda};
    end
  end
  // count wraps from nine to one on the rise after the ninth pulse, so the next byte counts from one
  always_ff @(posedge mclk) begin
    if (srst | start) begin
      cnt_r <= 4'h0;
    end else if (rise) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst | stop) begin
      first_r <= 1'b0;
      skip_r <= 1'b0;
    end else if (start) begin
      first_r <= 1'b1;
      skip_r <= 1'b0;
    end else if (ack_pulse & first_r) begin
      first_r <= 1'b0;
      skip_r <= ~hit;
      sel_r <= hit;
      rd_r <= sh_r[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  addr_ack_a: assert property (ack_pulse & first_r |-> s_pull == hit)
    else $error("address acknowledge disagrees with address match");
  addr_quiet_a: assert property (addr_bits & scl |-> !s_pull)
    else $error("slave pulls data during address bits");
  wr_ack_a: assert property (data_ack & ~rd_r |-> s_pull)
    else $error("written byte not acknowledged");
  rd_release_a: assert property (data_ack & rd_r |-> !s_pull)
    else $error("slave holds data in master acknowledge slot");
  slave_edge_a: assert property ($changed(s_pull) |-> !scl)
    else $error("slave changes data while clock high");
  skip_quiet_a: assert property (skip_r |-> !s_pull)
    else $error("unaddressed slave drives data");
  one_pull_a: assert property (scl |-> !(s_pull && m_pull))
    else $error("both ends pull data while clock high");
  stop_idle_a: assert property (stop |=> !s_pull [*8])
    else $error("slave drives data after stop");
  cover property (ack_pulse & first_r & hit);
  cover property (ack_pulse & ~first_r & rd_r);
  cover property (skip_r);
endmodule // bfi_link_asserts

// >>> dv/test_backlight_fault_i2c_slave.sv
// Purpose: both ends joined over the link, user side driven by the bench
// Assumes: inputs change on the falling edge of mclk
// Notes: driver queues expected responses, a monitor compares them
`timescale 1ns/1ps
`include "bfi_consts.svh"
module test_backlight_fault_i2c_slave;
  typedef struct packed {logic rd; logic nk; logic [7:0] d;} bfi_exp_t;
  logic mclk = 1'b0, srst = 1'b1;
  logic req_valid = 0, req_start = 0, req_stop = 0, req_read = 0;
  logic req_last = 0;
  logic [7:0] req_data = 8'h00;
  logic [5:0] lo = 0, mid = 0, hi = 0;
  logic uv_en = 0, uv_sel = 0, vlo = 1, vhi = 1, oc = 0, hot = 0;
  logic cool = 1, en_pin = 1;
  logic req_ready, rsp_valid, rsp_nack, led_enable, boost_enable, bus_busy;
  logic [7:0] rsp_data, brightness, r1, r2;
  logic [5:0] boost_request;
  logic [31:0] rnd = 32'h537A4DAF;
  bfi_exp_t q[$];
  bfi_exp_t e;
  int errors = 0, n_tests = 0, k;
  int fbit[4] = '{`BFI_BIT_OPEN, `BFI_BIT_SHORT, `BFI_BIT_OC, `BFI_BIT_TH};
  bfi_if link ();
  bfi_slave i_bfi_slave (.mclk(mclk), .srst(srst), .bus(link),
    .cmp_low(lo), .cmp_mid(mid), .cmp_high(hi),
    .undervoltage_detect_enable(uv_en),
    .undervoltage_threshold_select(uv_sel), .vin_above_low_set(vlo),
    .vin_above_low_clr(vlo), .vin_above_high_set(vhi),
    .vin_above_high_clr(vhi), .boost_overcurrent(oc),
    .temp_at_150(hot), .temp_below_130(cool),
    .enable_io_supply_pin(en_pin), .boost_request(boost_request),
    .led_enable(led_enable), .boost_enable(boost_enable),
    .bus_busy(bus_busy), .brightness(brightness));
  bfi_master i_bfi_master (.mclk(mclk), .srst(srst), .bus(link),
    .req_valid(req_valid), .req_start(req_start), .req_stop(req_stop),
    .req_read(req_read), .req_last(req_last), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack));
  bfi_link_asserts i_bfi_link_asserts (.mclk(mclk), .srst(srst),
    .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o),
    .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  always #25 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one byte per request, held until the master takes it
  task automatic xfer(input logic st, sp, rd, lst, input logic [7:0] d,
      input logic nk, input logic [7:0] ed);
    int n;
    q.push_back('{rd, nk, ed});
    @(negedge mclk);
    {req_valid, req_start, req_stop} = {1'b1, st, sp};
    {req_read, req_last} = {rd, lst};
    req_data = d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      errors++;
      $display("unexpected at %0t: request not taken", $time);
    end
    @(negedge mclk);
    req_valid = 1'b0;
  endtask
  task automatic rd_hdr(input logic [7:0] idx);
    xfer(1, 0, 0, 0, {`BFI_SLAVE_ADDR, 1'b0}, 0, 0);
    xfer(0, 0, 0, 0, idx, 0, 0);
    xfer(1, 0, 0, 0, {`BFI_SLAVE_ADDR, 1'b1}, 0, 0);
  endtask
  task automatic rd1(input logic [7:0] idx, input logic [7:0] exp);
    rd_hdr(idx);
    xfer(0, 1, 1, 1, 8'h00, 0, exp);
  endtask
  // stop goes out after the last response, so allow a few ticks more
  task automatic drain();
    int n;
    n = 0;
    while (q.size() != 0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (q.size() != 0) begin
      errors++;
      $display("unexpected at %0t: responses missing", $time);
    end
    repeat (300) @(negedge mclk);
  endtask
  always @(posedge mclk) begin
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0) begin
        errors++;
        $display("unexpected at %0t: response with none pending", $time);
      end else begin
        e = q.pop_front();
        if (e.rd) cmp_byte(rsp_data, e.d);
        else cmp_bit(rsp_nack, e.nk);
      end
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    cmp_byte(brightness, 8'h00);
    cmp_bit(bus_busy, 1'b0);
    r1 = rnd[7:0];
    rnd = lfsr(rnd);
    r2 = rnd[7:0];
    xfer(1, 0, 0, 0, {`BFI_SLAVE_ADDR, 1'b0}, 0, 0);
    xfer(0, 0, 0, 0, `BFI_REG_BRT, 0, 0);
    xfer(0, 0, 0, 0, r1, 0, 0);
    xfer(0, 1, 0, 0, r2, 0, 0);
    drain();
    cmp_byte(brightness, r1);
    rd_hdr(`BFI_REG_BRT);
    xfer(0, 0, 1, 0, 8'h00, 0, r1);
    xfer(0, 1, 1, 1, 8'h00, 0, r2);
    xfer(1, 0, 0, 0, {`BFI_SLAVE_ADDR, 1'b0}, 0, 0);
    drain();
    cmp_bit(bus_busy, 1'b1);
    xfer(0, 0, 0, 0, `BFI_REG_ID, 0, 0);
    xfer(1, 0, 0, 0, {`BFI_SLAVE_ADDR, 1'b1}, 0, 0);
    xfer(0, 1, 1, 1, 8'h00, 0, `BFI_ID_VALUE);
    drain();
    cmp_bit(bus_busy, 1'b0);
    xfer(1, 1, 0, 0, {`BFI_SLAVE_ADDR + 7'h01, 1'b0}, 1, 0);
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      lo = (i == 0) ? 6'h01 : 6'h00;
      hi = (i == 1) ? 6'h02 : 6'h00;
      mid = hi;
      {oc, hot, cool} = {i == 2, i == 3, i != 3};
      k = 0;
      while (i == 0 && boost_request !== `BFI_VREQ_MAX && k < 20000) begin
        @(negedge mclk);
        k++;
      end
      repeat (20) @(negedge mclk);
      if (i == 0) cmp_byte({2'h0, boost_request}, 8'(`BFI_VREQ_MAX));
      if (i == 2) cmp_bit(boost_enable, 1'b0);
      if (i == 3) cmp_bit(led_enable, 1'b0);
      // cause gone first: the bit stays latched until read
      {lo, mid, hi, oc, hot} = 20'h0;
      repeat (20) @(negedge mclk);
      rd1(`BFI_REG_FAULT, 8'h01 << fbit[i]);
      rd1(`BFI_REG_FAULT, 8'h00);
    end
    cmp_bit(led_enable, 1'b0);
    cool = 1'b1;
    repeat (20) @(negedge mclk);
    cmp_bit(led_enable, 1'b1);
    cmp_bit(boost_enable, 1'b1);
    {uv_en, vlo} = 2'b10;
    repeat (20) @(negedge mclk);
    cmp_bit(led_enable, 1'b0);
    cmp_bit(boost_enable, 1'b0);
    vlo = 1'b1;
    repeat (20) @(negedge mclk);
    cmp_bit(led_enable, 1'b1);
    en_pin = 1'b0;
    repeat (20) @(negedge mclk);
    en_pin = 1'b1;
    rd1(`BFI_REG_FAULT, 8'h00);
    {uv_sel, vhi} = 2'b10;
    repeat (20) @(negedge mclk);
    uv_en = 1'b0;
    rd1(`BFI_REG_FAULT, 8'h01 << `BFI_BIT_UV);
    rd1(`BFI_REG_FAULT, 8'h00);
    drain();
    test_done();
  end
endmodule // test_backlight_fault_i2c_slave
